/* drtt_timing.v */
// Refresh scheduling and read turnaround timing with register slave
`timescale 1ns/10ps
`include "drtt_defs.vh"

module drtt_timing #(
  parameter ODT_GAP = 2            // Extra clocks for termination settle
) (
  input  wire        clk_i,        // Controller clock, 40 MHz
  input  wire        reset_n_i,    // Synchronous reset, active low
  input  wire [7:0]  address_i,    // Avalon byte address
  input  wire        read_i,       // Avalon read
  input  wire        write_i,      // Avalon write
  input  wire [31:0] writedata_i,  // Avalon write data
  input  wire [3:0]  byteenable_i, // Avalon byte enables
  output reg  [31:0] readdata_o,   // Avalon read data
  output reg         waitrequest_o,// Avalon wait request
  input  wire        ref_issue_i,  // Auto-refresh issued this cycle
  input  wire [1:0]  ref_dimm_i,   // Logical DIMM of that refresh
  input  wire        rd_end_i,     // Last clock of a read column strobe
  input  wire [2:0]  rd_cs_i,      // Chip select of that read
  input  wire        odt_chg_i,    // Next read changes termination
  output reg         ref_req_o,    // Refresh wanted, level
  output reg  [3:0]  dimm_ok_o,    // DIMM may take activate or refresh
  output reg  [7:0]  rd_cs_ok_o    // Read column strobe allowed per CS
);

  // Register storage
  reg [31:0] timing_high_reg;      // Timing-high register
  reg [31:0] mode_cfg_reg;         // Mode configuration
  reg [15:0] clk_period_reg;       // Memory clock period, ps
  reg        ack_reg;              // Bus answer phase flag

  // Decoded fields
  wire        ddr3_sel  = mode_cfg_reg[`DRTT_MODE_DDR3_BIT];
  wire        refresh_off =
              timing_high_reg[`DRTT_REF_OFF_BIT];
  wire [1:0]  ref_rate  =
              timing_high_reg[`DRTT_REF_RATE_HI:`DRTT_REF_RATE_LO];
  wire [1:0]  rdrd_lo   = timing_high_reg[`DRTT_RDRD_HI:`DRTT_RDRD_LO];
  wire [1:0]  rdrd_up   =
              mode_cfg_reg[`DRTT_MODE_RDRD_HI:`DRTT_MODE_RDRD_LO];
  // Zero period would divide by zero, so treat it as one
  wire [23:0] period_ps = (clk_period_reg == 16'h0000) ?
              24'h000001 : {8'h00, clk_period_reg};

  // Refresh-cycle code to picoseconds; reserved picks longest
  function [23:0] trfc_ps;
    input [2:0] code;
    input       ddr3;
    begin
      if (ddr3) begin
        case (code)
          3'h1:    trfc_ps = `DRTT_T_DDR3_1_PS;
          3'h2:    trfc_ps = `DRTT_T_DDR3_2_PS;
          3'h3:    trfc_ps = `DRTT_T_DDR3_3_PS;
          3'h4:    trfc_ps = `DRTT_T_DDR3_4_PS;
          default: trfc_ps = `DRTT_T_DDR3_5_PS;
        endcase
      end else begin
        case (code)
          3'h0:    trfc_ps = `DRTT_T_DDR2_0_PS;
          3'h1:    trfc_ps = `DRTT_T_DDR2_1_PS;
          3'h2:    trfc_ps = `DRTT_T_DDR2_2_PS;
          3'h3:    trfc_ps = `DRTT_T_DDR2_3_PS;
          default: trfc_ps = `DRTT_T_DDR2_4_PS;
        endcase
      end
    end
  endfunction

  // Picoseconds to whole clocks, rounded up, at least one
  function [23:0] ceil_clk;
    input [23:0] t;
    input [23:0] p;
    reg   [24:0] sum;
    reg   [24:0] q;
    begin
      sum = {1'b0, t} + {1'b0, p} - 25'd1;
      q = sum / {1'b0, p};
      if (q == 25'd0)
        ceil_clk = 24'd1;
      else
        ceil_clk = q[23:0];
    end
  endfunction

  // Refresh interval: reserved and undefined codes use the short one
  wire [23:0] refi_ps  = (ref_rate == 2'b10) ?
              `DRTT_T_REFI_LONG_PS : `DRTT_T_REFI_SHORT_PS;
  // Average interval rounds down, never below one clock
  wire [23:0] refi_div = refi_ps / period_ps;
  wire [23:0] refi_clk = (refi_div == 24'd0) ? 24'd1 : refi_div;

  // Read gap in clocks; DDR3 reserved codes clamp to the top
  reg [3:0] rdrd_code;             // Effective gap code
  reg [4:0] rdrd_clk;              // Gap in clocks
  always @* begin
    if (ddr3_sel) begin
      rdrd_code = {rdrd_up, rdrd_lo};
      if (rdrd_code > `DRTT_RDRD_MAX)
        rdrd_code = `DRTT_RDRD_MAX;
    end else begin
      rdrd_code = {2'b00, rdrd_lo};
    end
    rdrd_clk = {1'b0, rdrd_code} + {1'b0, `DRTT_RDRD_BASE};
    if (odt_chg_i)
      rdrd_clk = rdrd_clk + ODT_GAP[4:0];
  end

  // Bus: one wait cycle, then answer; write lands on the answer edge
  wire bus_req   = read_i | write_i;
  wire wr_commit = write_i & ack_reg;
  reg  [31:0] rd_mux;              // Read data selection
  always @* begin
    rd_mux = 32'h00000000;         // Unmapped reads give zero
    case (address_i)
      `DRTT_OFS_TIMING_HIGH: rd_mux = timing_high_reg;
      `DRTT_OFS_MODE_CFG:    rd_mux = mode_cfg_reg;
      `DRTT_OFS_CLK_PERIOD:  rd_mux = {16'h0000, clk_period_reg};
      `DRTT_OFS_STATUS:      rd_mux = {18'h00000, rd_cs_ok_o,
                                       dimm_ok_o, 1'b0, ref_req_o};
      default:               rd_mux = 32'h00000000;
    endcase
  end

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          merge[8*k +: 8] = wd[8*k +: 8];
    end
  endfunction

  wire [31:0] period_merged = merge({16'h0000, clk_period_reg},
                                    writedata_i, byteenable_i);

  // Bus handshake and register writes
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_reg         <= 1'b0;
      waitrequest_o   <= 1'b1;
      readdata_o      <= 32'h00000000;
      timing_high_reg <= `DRTT_RST_TIMING_HIGH;
      mode_cfg_reg    <= `DRTT_RST_MODE_CFG;
      clk_period_reg  <= `DRTT_RST_CLK_PERIOD;
    end else begin
      if (bus_req && !ack_reg) begin
        ack_reg       <= 1'b1;     // Answer next cycle
        waitrequest_o <= 1'b0;
        readdata_o    <= read_i ? rd_mux : 32'h00000000;
      end else begin
        ack_reg       <= 1'b0;     // Back to waiting
        waitrequest_o <= 1'b1;
      end
      if (wr_commit) begin
        case (address_i)
          `DRTT_OFS_TIMING_HIGH:
            timing_high_reg <= merge(timing_high_reg, writedata_i,
                                     byteenable_i)
                               & `DRTT_TH_WMASK;
          `DRTT_OFS_MODE_CFG:
            mode_cfg_reg <= merge(mode_cfg_reg, writedata_i,
                                  byteenable_i) & 32'h0000000d;
          `DRTT_OFS_CLK_PERIOD:
            clk_period_reg <= period_merged[15:0];
          default: begin
            // Unmapped writes are dropped
          end
        endcase
      end
    end
  end

  // Refresh interval timer and pending request
  reg [23:0] refi_cnt_reg;         // Clocks until next request
  reg        ref_pend_reg;         // Request waiting for issue
  reg        ref_pend_next;
  always @* begin
    ref_pend_next = ref_pend_reg;
    if (ref_issue_i)
      ref_pend_next = 1'b0;
    if (refi_cnt_reg <= 24'd1)
      ref_pend_next = 1'b1;        // Set beats issue in same cycle
    if (refresh_off)
      ref_pend_next = 1'b0;
  end

  // Interval counting; held at reload while refresh is off
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      refi_cnt_reg <= 24'h000001;
      ref_pend_reg <= 1'b0;
      ref_req_o    <= 1'b0;
    end else begin
      if (refresh_off || refi_cnt_reg <= 24'd1)
        refi_cnt_reg <= refi_clk;
      else
        refi_cnt_reg <= refi_cnt_reg - 24'd1;
      ref_pend_reg <= ref_pend_next;
      ref_req_o    <= ref_pend_next;
    end
  end

  // Per-DIMM refresh recovery timers
  wire [3:0] dimm_free_next;       // DIMM readiness for next cycle
  genvar d;
  generate
    for (d = 0; d < 4; d = d + 1) begin : g_dimm
      localparam [1:0] DIDX = d;   // This DIMM's index, two bits
      wire [2:0]  code = timing_high_reg[`DRTT_REFRESH_CYCLE_DIMM0_LO + 3*d +: 3];
      wire [23:0] need = ceil_clk(trfc_ps(code, ddr3_sel),
                                  period_ps);
      reg  [23:0] cnt_reg;         // Clocks left before activate
      reg  [23:0] cnt_next;
      always @* begin
        cnt_next = cnt_reg;
        if (ref_issue_i && ref_dimm_i == DIDX)
          cnt_next = need - 24'd1;
        else if (cnt_reg != 24'd0)
          cnt_next = cnt_reg - 24'd1;
      end
      assign dimm_free_next[d] = (cnt_next == 24'd0);
      // Output follows next count so it lines up with the count
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          cnt_reg      <= 24'h000000;
          dimm_ok_o[d] <= 1'b1;
        end else begin
          cnt_reg      <= cnt_next;
          dimm_ok_o[d] <= (cnt_next == 24'd0);
        end
      end
    end
  endgenerate

  // Read turnaround: same CS free once its DIMM is free, others also wait the gap
  reg [4:0] rd_cnt_reg;            // Clocks left in read gap
  reg [4:0] rd_cnt_next;
  reg [2:0] rd_last_cs_reg;        // Chip select of last burst
  reg [2:0] rd_last_cs_next;
  always @* begin
    rd_cnt_next     = rd_cnt_reg;
    rd_last_cs_next = rd_last_cs_reg;
    if (rd_end_i) begin
      rd_cnt_next     = rdrd_clk - 5'd1;
      rd_last_cs_next = rd_cs_i;
    end else if (rd_cnt_reg != 5'd0) begin
      rd_cnt_next = rd_cnt_reg - 5'd1;
    end
  end

  // Per-CS read permission; CS pair maps to logical DIMM
  integer c;
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      rd_cnt_reg     <= 5'h00;
      rd_last_cs_reg <= 3'h0;
      rd_cs_ok_o     <= 8'hff;
    end else begin
      rd_cnt_reg     <= rd_cnt_next;
      rd_last_cs_reg <= rd_last_cs_next;
      for (c = 0; c < 8; c = c + 1)
        rd_cs_ok_o[c] <= ((rd_cnt_next == 5'd0) ||
                          (c[2:0] == rd_last_cs_next)) &&
                         dimm_ok_next(c[2:1]);
    end
  end

  // DIMM readiness as seen next cycle, for the CS pair
  function dimm_ok_next;
    input [1:0] idx;
    begin
      case (idx)
        2'd0:    dimm_ok_next = dimm_free_next[0];
        2'd1:    dimm_ok_next = dimm_free_next[1];
        2'd2:    dimm_ok_next = dimm_free_next[2];
        default: dimm_ok_next = dimm_free_next[3];
      endcase
    end
  endfunction

endmodule

/* drtt_defs.vh */
// Constants for the refresh and read turnaround timing block
// Functional notes
// - Timing-high register resets to all zeros
// - Four three-bit refresh-cycle fields, DIMMs 3-0
// - Hold activate/refresh after refresh for cycle time
// - Logical DIMM index is chip select pair
// - DDR2 refresh-cycle codes 75 to 327.5 ns
// - DDR3 refresh-cycle codes 90 to 350 ns
// - Refresh-off bit stops automatic refresh requests
// - Refresh rate 7.8 or 3.9 microseconds
// - Read gap from burst end, other chip select
// - Termination change adds extra read gap
// - DDR3 four-bit read gap 2 to 10 clocks
`ifndef DRTT_DEFS_VH
`define DRTT_DEFS_VH

// Register byte offsets
`define DRTT_OFS_TIMING_HIGH 8'h8c
`define DRTT_OFS_MODE_CFG    8'h90
`define DRTT_OFS_CLK_PERIOD  8'h94
`define DRTT_OFS_STATUS      8'h98

// Reset values
`define DRTT_RST_TIMING_HIGH 32'h00000000
`define DRTT_RST_MODE_CFG    32'h00000000
`define DRTT_RST_CLK_PERIOD  16'h61a8

// Writable bits of timing-high, bit 19 reserved
`define DRTT_TH_WMASK        32'hfff7ffff

// Timing-high field positions
`define DRTT_REFRESH_CYCLE_DIMM3_HI 31
`define DRTT_REFRESH_CYCLE_DIMM0_LO 20
`define DRTT_REF_OFF_BIT 18
`define DRTT_REF_RATE_HI 17
`define DRTT_REF_RATE_LO 16
`define DRTT_RDRD_HI 15
`define DRTT_RDRD_LO 14

// Mode configuration field positions
`define DRTT_MODE_DDR3_BIT 0
`define DRTT_MODE_RDRD_HI 3
`define DRTT_MODE_RDRD_LO 2

// Refresh-cycle times in picoseconds
`define DRTT_T_DDR2_0_PS 24'd75000
`define DRTT_T_DDR2_1_PS 24'd105000
`define DRTT_T_DDR2_2_PS 24'd127500
`define DRTT_T_DDR2_3_PS 24'd195000
`define DRTT_T_DDR2_4_PS 24'd327500
`define DRTT_T_DDR3_1_PS 24'd90000
`define DRTT_T_DDR3_2_PS 24'd110000
`define DRTT_T_DDR3_3_PS 24'd160000
`define DRTT_T_DDR3_4_PS 24'd300000
`define DRTT_T_DDR3_5_PS 24'd350000

// Refresh intervals in picoseconds
`define DRTT_T_REFI_LONG_PS  24'd7800000
`define DRTT_T_REFI_SHORT_PS 24'd3900000

// Read gap base and limits in clocks
`define DRTT_RDRD_BASE 4'd2
`define DRTT_RDRD_MAX  4'd8

`endif

/* drtt_timing_props.sv */
// Port assertions for the refresh and read gap timing block
`timescale 1ns/10ps
`include "drtt_defs.vh"
module drtt_timing_props (
  input logic        clk_i,         // Clock
  input logic        reset_n_i,     // Reset
  input logic [7:0]  address_i,     // Address
  input logic        read_i,        // Read
  input logic        write_i,       // Write
  input logic [31:0] writedata_i,   // Write data
  input logic [3:0]  byteenable_i,  // Lanes
  input logic [31:0] readdata_o,    // Read data
  input logic        waitrequest_o, // Wait
  input logic        ref_issue_i,   // Refresh sent
  input logic [1:0]  ref_dimm_i,    // Its DIMM
  input logic        rd_end_i,      // Read end
  input logic [2:0]  rd_cs_i,       // Its CS
  input logic        odt_chg_i,     // Termination change
  input logic        ref_req_o,     // Refresh wanted
  input logic [3:0]  dimm_ok_o,     // DIMM free
  input logic [7:0]  rd_cs_ok_o     // CS free
);
  logic roff_q; // Shadow of refresh_off
  // Follow committed writes to lane 2 of timing-high
  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      roff_q <= 1'b0;
    else if (write_i && !waitrequest_o && byteenable_i[2] &&
             address_i == `DRTT_OFS_TIMING_HIGH)
      roff_q <= writedata_i[18];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req; (read_i || write_i) && waitrequest_o; endsequence
  sequence s_ans; !waitrequest_o ##1 waitrequest_o; endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer not one cycle");
  a_rst_idle: assert property (disable iff (1'b0) !reset_n_i |=>
    waitrequest_o && !ref_req_o && dimm_ok_o == 4'hf && rd_cs_ok_o == 8'hff)
    else $error("outputs not idle after reset");
  a_ref_block: assert property (
    ref_issue_i |=> !dimm_ok_o[$past(ref_dimm_i)])
    else $error("DIMM free right after refresh");
  a_ref_cause: assert property (
    $fell(dimm_ok_o[0]) |-> $past(ref_issue_i) && $past(ref_dimm_i) == 2'h0)
    else $error("DIMM 0 blocked without its refresh");
  a_ref_back: assert property (
    $fell(dimm_ok_o[0]) |-> ##[1:20] dimm_ok_o[0])
    else $error("DIMM 0 never freed");
  a_ref_off: assert property (roff_q |=> !ref_req_o)
    else $error("refresh wanted while off");
  a_rd_block: assert property (
    rd_end_i |=> (rd_cs_ok_o & ~(8'h01 << $past(rd_cs_i))) == 8'h00)
    else $error("other CS free too soon");
  a_rd_same: assert property (
    rd_end_i && rd_cs_ok_o == 8'hff |=> rd_cs_ok_o[$past(rd_cs_i)])
    else $error("same CS blocked");
endmodule
bind drtt_timing drtt_timing_props i_props (.*);

/* drtt_sched.sv */
// Memory-side scheduler model facing the timing block
`timescale 1ns/10ps
module drtt_sched (
  input  logic       clk_i,     // Clock
  input  logic       reset_n_i, // Reset
  input  logic       slow_i,    // Refresh late
  input  logic       rd_go_i,   // Send a read
  input  logic [2:0] rd_sel_i,  // Its CS
  input  logic       odt_sel_i, // Its termination
  input  logic       req_i,     // Refresh wanted
  input  logic [3:0] ok_i,      // DIMM free
  input  logic [7:0] cs_ok_i,   // CS free
  output logic       issue_o,   // Refresh sent
  output logic [1:0] dimm_o,    // Its DIMM
  output logic       end_o,     // Read end
  output logic [2:0] cs_o,      // Its CS
  output logic       odt_o      // Its termination
);
  logic [1:0] dimm_q; // DIMM in turn
  logic [2:0] cs_q;   // Pending CS
  logic odt_q, pend_q, tick_q;
  // Idle lines invert so stale values are never trusted
  assign dimm_o = issue_o ? dimm_q : ~dimm_q;
  assign cs_o = end_o ? cs_q : ~cs_q;
  assign odt_o = end_o ? odt_q : ~odt_q;
  // Commands go only to free DIMMs and chip selects
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      {issue_o, end_o, pend_q, tick_q, odt_q} <= 5'h0;
      {dimm_q, cs_q} <= 5'h0;
    end else begin
      tick_q <= ~tick_q;
      issue_o <= req_i && &ok_i && !issue_o && (!slow_i || tick_q);
      if (issue_o)
        dimm_q <= dimm_q + 2'h1;
      if (rd_go_i) begin
        pend_q <= 1'b1;
        cs_q <= rd_sel_i;
        odt_q <= odt_sel_i;
      end else if (end_o)
        pend_q <= 1'b0;
      end_o <= pend_q && cs_ok_i[cs_q] && ok_i[cs_q[2:1]] && !end_o;
    end
  end
endmodule

/* tb_drtt_timing.sv */
// Self-checking bench for the refresh and read gap timing block
`timescale 1ns/10ps
`include "drtt_defs.vh"
module tb_drtt_timing;
  localparam ODT = 3; // Termination gap under test
  logic clk_i = 1'b0, reset_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0;
  logic [7:0] address_i = 8'h0;
  logic [31:0] writedata_i = 32'h0, readdata_o, q, th = 32'h0;
  logic [3:0] byteenable_i = 4'hf, dimm_ok_o, c;
  logic waitrequest_o, ref_issue_i, rd_end_i, odt_chg_i, ref_req_o;
  logic [1:0] ref_dimm_i;
  logic [2:0] rd_cs_i, rd_sel = 3'h0;
  logic [7:0] rd_cs_ok_o;
  logic slow = 1'b0, rd_go = 1'b0, odt_sel = 1'b0;
  logic [31:0] rnd = 32'd53719; // Random source
  int errors = 0, cmp_count = 0, n;
  drtt_timing #(.ODT_GAP(ODT)) i_dut (.*);
  drtt_sched i_sched (.clk_i, .reset_n_i, .slow_i(slow), .rd_go_i(rd_go),
    .rd_sel_i(rd_sel), .odt_sel_i(odt_sel), .req_i(ref_req_o),
    .ok_i(dimm_ok_o), .cs_ok_i(rd_cs_ok_o), .issue_o(ref_issue_i),
    .dimm_o(ref_dimm_i), .end_o(rd_end_i), .cs_o(rd_cs_i), .odt_o(odt_chg_i));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Refresh-cycle time in ps; reserved codes take the longest
  function automatic int trfc(input logic [3:0] k);
    case (k)
      4'h0: return 75000;
      4'h1: return 105000;
      4'h2: return 127500;
      4'h3: return 195000;
      4'h9: return 90000;
      4'ha: return 110000;
      4'hb: return 160000;
      4'hc: return 300000;
      default: return k[3] ? 350000 : 327500;
    endcase
  endfunction
  function automatic int gap(input logic d3, input logic [3:0] k, input logic o);
    return (d3 ? (k > 4'h8 ? 10 : 2 + k) : 2 + k[1:0]) + (o ? ODT : 0);
  endfunction
  task automatic cmpn(input int g, input int e);
    cmp_count++;
    if (g != e) begin
      errors++;
      $display("CHECK FAILED %0t count %0d exp %0d", $time, g, e);
    end
  endtask
  task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %0t data %h exp %h", $time, g, e);
    end
  endtask
  // One bus transfer; held until wait drops at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    write_i <= w;
    read_i <= !w;
    do @(posedge clk_i); while (waitrequest_o !== 1'b0);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  // Cycles from one rising refresh request to the next
  task automatic rise_span();
    do tick(); while (ref_req_o !== 1'b1);
    n = 0;
    do begin
      n++;
      tick();
    end while (ref_req_o !== 1'b0);
    do begin
      n++;
      tick();
    end while (ref_req_o !== 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    bus(1'b0, `DRTT_OFS_TIMING_HIGH, 32'h0, 4'hf);
    cmp32(q, 32'h0);
    bus(1'b1, 8'ha0, 32'hffffffff, 4'hf);
    bus(1'b0, 8'ha0, 32'h0, 4'hf);
    cmp32(q, 32'h0);
    // Random lanes; the reserved bit reads zero
    repeat (8) begin
      rnd = nxt(rnd);
      bus(1'b1, `DRTT_OFS_TIMING_HIGH, rnd, rnd[7:4]);
      for (int b = 0; b < 4; b++)
        if (rnd[4 + b]) th[8*b +: 8] = rnd[8*b +: 8];
      bus(1'b0, `DRTT_OFS_TIMING_HIGH, 32'h0, 4'hf);
      cmp32(q, th & `DRTT_TH_WMASK);
    end
    // Every refresh-cycle code of both types; rate code cycles along
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      bus(1'b1, `DRTT_OFS_MODE_CFG, {31'h0, c[3]}, 4'hf);
      bus(1'b1, `DRTT_OFS_TIMING_HIGH, {{4{c[2:0]}}, 2'h0, c[1:0], 16'h0}, 4'hf);
      rnd = nxt(rnd);
      slow <= rnd[0];
      repeat (2) begin
        do tick(); while (dimm_ok_o === 4'hf);
        n = 0;
        while (dimm_ok_o !== 4'hf) begin
          n++;
          tick();
        end
      end
      cmpn(n, (trfc(c) + 24999) / 25000 - 1);
      rise_span();
      cmpn(n, (c[1:0] == 2'h2 ? 7800000 : 3900000) / 25000);
    end
    bus(1'b1, `DRTT_OFS_TIMING_HIGH, 32'h00070000, 4'hf);
    n = 0;
    repeat (400) begin
      tick();
      n += (ref_req_o !== 1'b0);
    end
    cmpn(n, 0);
    // Read gap for every code of both types, random termination
    for (int i = 0; i < 20; i++) begin
      c = 4'(i < 4 ? i : i - 4);
      rnd = nxt(rnd);
      bus(1'b1, `DRTT_OFS_MODE_CFG, {28'h0, c[3:2], 1'b0, i > 3}, 4'hf);
      bus(1'b1, `DRTT_OFS_TIMING_HIGH, {16'h0007, c[1:0], 14'h0}, 4'hf);
      rd_sel <= rnd[2:0];
      odt_sel <= rnd[3];
      rd_go <= 1'b1;
      @(posedge clk_i);
      rd_go <= 1'b0;
      do tick(); while (rd_end_i !== 1'b1);
      n = 0;
      do begin
        n++;
        tick();
      end while (rd_cs_ok_o !== 8'hff);
      cmpn(n, gap(i > 3, c, rnd[3]));
    end
    // Slower memory clock shortens the interval in clocks
    bus(1'b1, `DRTT_OFS_CLK_PERIOD, 32'h0000ffff, 4'hf);
    bus(1'b0, `DRTT_OFS_CLK_PERIOD, 32'h0, 4'hf);
    cmp32(q, 32'h0000ffff);
    bus(1'b1, `DRTT_OFS_TIMING_HIGH, 32'h00030000, 4'hf);
    rise_span();
    cmpn(n, 3900000 / 65535);
    finish_test();
  end
  // Hang guard, well past the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    errors++;
    finish_test();
  end
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
endmodule
